/* include/dufc_pkg.sv */
package dufc_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'hD4;
  localparam logic [7:0] HIGH_ADDR = 8'hD3;
  localparam logic [7:0] LOW_ADDR = 8'hD2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h9F;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int EN_BIT = 7;
  localparam int MODE_HI = 4;
  localparam int MODE_LO = 3;
  localparam int FMT_HI = 2;
  localparam int FMT_LO = 0;
  localparam int CODE_W = 12;
  // ----------------------------------------
  // update sources
  // ----------------------------------------
  typedef enum logic [1:0] {
    DUFC_SRC_WRITE = 2'h0,
    DUFC_SRC_TMR3 = 2'h1,
    DUFC_SRC_TMR4 = 2'h2,
    DUFC_SRC_TMR2 = 2'h3
  } dufc_src_e;
endpackage : dufc_pkg

/* include/dufc_code_if.sv */
interface dufc_code_if;
  logic [7:0] high_byte;
  logic [7:0] low_byte;
  logic [2:0] fmt;
  logic [11:0] code;
  modport ctrl (output high_byte, output low_byte, output fmt, input code);
  modport fmt_side (input high_byte, input low_byte, input fmt, output code);
endinterface : dufc_code_if

/* core/dufc_format.sv */
module dufc_format (
  dufc_code_if.fmt_side cif
);
  // ----------------------------------------
  // justification mux
  // ----------------------------------------
  // bits outside the selected field never reach the code
  wire [11:0] code_f0 = {cif.high_byte[3:0], cif.low_byte[7:0]};
  wire [11:0] code_f1 = {cif.high_byte[4:0], cif.low_byte[7:1]};
  wire [11:0] code_f2 = {cif.high_byte[5:0], cif.low_byte[7:2]};
  wire [11:0] code_f3 = {cif.high_byte[6:0], cif.low_byte[7:3]};
  wire [11:0] code_f4 = {cif.high_byte[7:0], cif.low_byte[7:4]};
  assign cif.code = cif.fmt[2] ? code_f4 :
                    (cif.fmt[1:0] == 2'h3) ? code_f3 :
                    (cif.fmt[1:0] == 2'h2) ? code_f2 :
                    (cif.fmt[1:0] == 2'h1) ? code_f1 :
                    code_f0;
endmodule : dufc_format

/* core/dufc_trigger.sv */
module dufc_trigger (
  // clock and source select
  input wire logic clk_in,
  input wire logic [1:0] mode_in,
  // events
  input wire logic high_wr_in,
  input wire logic t2_ovf_in,
  input wire logic t3_ovf_in,
  input wire logic t4_ovf_in,
  // result
  output logic load_out
);
  // ----------------------------------------
  // source selection
  // ----------------------------------------
  wire sel_write = (mode_in == dufc_pkg::DUFC_SRC_WRITE) && high_wr_in;
  wire sel_t3 = (mode_in == dufc_pkg::DUFC_SRC_TMR3) && t3_ovf_in;
  wire sel_t4 = (mode_in == dufc_pkg::DUFC_SRC_TMR4) && t4_ovf_in;
  wire sel_t2 = (mode_in == dufc_pkg::DUFC_SRC_TMR2) && t2_ovf_in;
  assign load_out = sel_write | sel_t3 | sel_t4 | sel_t2;

  // timer mode must ignore high-byte writes
  a_write_ignored: assert property (@(posedge clk_in)
    (mode_in != 2'h0 && !t2_ovf_in && !t3_ovf_in && !t4_ovf_in) |-> !load_out)
    else $error("load without selected event");
endmodule : dufc_trigger

/* core/dufc_top.sv */
// How it works
// - Enable bit 7 low keeps the output pin off and the converter shut down; high runs it.
// - Control bits 6 and 5 read as zero and ignore writes.
// - Update source 00 loads the converter latch on a high data byte write.
// - Update source 01 loads the latch on each timer 3 overflow.
// - Update source 10 loads the latch on each timer 4 overflow.
// - Update source 11 loads the latch on each timer 2 overflow.
// - Justification 000 takes high bits 3:0 and the whole low byte.
// - Justification 001 takes high bits 4:0 and low bits 7:1.
// - Justification 010 takes high bits 5:0 and low bits 7:2.
// - Justification 011 takes high bits 6:0 and low bits 7:3.
// - Justification 1xx takes the whole high byte and low bits 7:4.
// - In write mode a low byte write is held until the next high byte write.
// - In timer modes both data bytes are held until the chosen timer overflows.
// - The latched code is a 12-bit unsigned value from 0x000 to 0xFFF.
module dufc_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // special function register port
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  // timer overflow pulses, same clock
  input wire logic t2_ovf_in,
  input wire logic t3_ovf_in,
  input wire logic t4_ovf_in,
  // converter side
  output logic [11:0] code_latch_out,
  output logic converter_one_enable_out,
  output logic pin_drive_out,
  output logic shutdown_out
);
  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0] converter_one_control;
  logic [7:0] code_high_byte;
  logic [7:0] code_low_byte;
  logic [11:0] code_latch;
  logic load;

  dufc_code_if cif ();

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire ctrl_wr = sfr_wr_in && (sfr_addr_in == dufc_pkg::CTRL_ADDR);
  wire high_wr = sfr_wr_in && (sfr_addr_in == dufc_pkg::HIGH_ADDR);
  wire low_wr = sfr_wr_in && (sfr_addr_in == dufc_pkg::LOW_ADDR);
  wire [1:0] update_source_select =
    converter_one_control[dufc_pkg::MODE_HI:dufc_pkg::MODE_LO];
  wire [2:0] word_justification_select =
    converter_one_control[dufc_pkg::FMT_HI:dufc_pkg::FMT_LO];
  wire converter_one_enable = converter_one_control[dufc_pkg::EN_BIT];
  // unused bits are masked on write so a read returns them as zero
  wire [7:0] next_control = sfr_wdata_in & dufc_pkg::CTRL_WMASK;
  // the formatter sees the byte being written, so a high write loads fresh data
  wire [7:0] next_high = high_wr ? sfr_wdata_in : code_high_byte;
  wire [7:0] next_low = low_wr ? sfr_wdata_in : code_low_byte;
  wire [7:0] rdata_sel =
    (sfr_addr_in == dufc_pkg::CTRL_ADDR) ? converter_one_control :
    (sfr_addr_in == dufc_pkg::HIGH_ADDR) ? code_high_byte :
    (sfr_addr_in == dufc_pkg::LOW_ADDR) ? code_low_byte : 8'h00;

  // formatter inputs
  assign cif.high_byte = next_high;
  assign cif.low_byte = next_low;
  assign cif.fmt = word_justification_select;

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  dufc_format u_format (
    .cif(cif.fmt_side)
  );

  dufc_trigger u_trigger (
    .clk_in(clk_in),
    .mode_in(update_source_select),
    .high_wr_in(high_wr),
    .t2_ovf_in(t2_ovf_in),
    .t3_ovf_in(t3_ovf_in),
    .t4_ovf_in(t4_ovf_in),
    .load_out(load)
  );

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // control register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      converter_one_control <= dufc_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      converter_one_control <= next_control;
    end
  end

  // data bytes are held in flops; the formatter sees a written byte in the same cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      code_high_byte <= dufc_pkg::DATA_RESET;
      code_low_byte <= dufc_pkg::DATA_RESET;
    end else begin
      code_high_byte <= next_high;
      code_low_byte <= next_low;
    end
  end

  // converter input latch, 12-bit unsigned
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      code_latch <= 12'h000;
    end else if (load) begin
      code_latch <= cif.code;
    end
  end

  // read data and converter controls straight from flops
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sfr_rdata_out <= 8'h00;
      converter_one_enable_out <= 1'b0;
      pin_drive_out <= 1'b0;
      shutdown_out <= 1'b1;
    end else begin
      sfr_rdata_out <= sfr_rd_in ? rdata_sel : sfr_rdata_out;
      converter_one_enable_out <= converter_one_enable;
      pin_drive_out <= converter_one_enable;
      shutdown_out <= ~converter_one_enable;
    end
  end

  assign code_latch_out = code_latch;

  // ----------------------------------------
  // check sequences
  // ----------------------------------------
  // a low byte write that arrives without a high byte write
  sequence s_low_alone;
    low_wr && !high_wr;
  endsequence

  // the high byte write that should follow it; the window is bounded to
  // keep the checker small, so longer gaps between the two go unwatched
  sequence s_low_then_high;
    s_low_alone ##[1:16] high_wr;
  endsequence

  // the event that loads the latch in write-triggered mode
  sequence s_write_tick;
    (update_source_select == 2'h0) && high_wr;
  endsequence

  // the overflow of whichever timer the update source selects
  sequence s_timer_tick;
    ((update_source_select == 2'h1) && t3_ovf_in) ||
    ((update_source_select == 2'h2) && t4_ovf_in) ||
    ((update_source_select == 2'h3) && t2_ovf_in);
  endsequence

  // a high byte write while a timer owns the update
  sequence s_timer_mode_write;
    (update_source_select != 2'h0) && high_wr;
  endsequence

  // ----------------------------------------
  // checks: enable and control register
  // ----------------------------------------
  // pins follow the enable one cycle late, never both on
  a_enable_pins: assert property (@(posedge clk_in) disable iff (rst_in)
    ##1 (pin_drive_out == $past(converter_one_enable)) && (shutdown_out == !pin_drive_out))
    else $error("pin drive not following enable");

  a_enable_copy: assert property (@(posedge clk_in) disable iff (rst_in)
    ##1 converter_one_enable_out == $past(converter_one_enable))
    else $error("enable output not following control bit");

  // reset must leave the converter shut down with a zero code
  a_reset_quiet: assert property (@(posedge clk_in)
    rst_in |=> (code_latch_out == 12'h000) && shutdown_out &&
      !pin_drive_out && !converter_one_enable_out)
    else $error("reset did not quiet the converter");

  // a control write is the only thing that may change the register
  a_ctrl_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    !ctrl_wr |=> $stable(converter_one_control))
    else $error("control register changed without a write");

  a_unused_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    converter_one_control[6:5] == 2'h0)
    else $error("unused control bits not zero");

  // kept bits come from the written byte, the unused pair never does
  a_ctrl_write: assert property (@(posedge clk_in) disable iff (rst_in)
    ctrl_wr |=> converter_one_control ==
      {$past(sfr_wdata_in[7]), 2'h0, $past(sfr_wdata_in[4:0])})
    else $error("control write not stored as expected");

  a_read_unused: assert property (@(posedge clk_in) disable iff (rst_in)
    (sfr_rd_in && (sfr_addr_in == dufc_pkg::CTRL_ADDR)) |=> sfr_rdata_out[6:5] == 2'h0)
    else $error("control read shows unused bits");

  // read data stands until the next read strobe
  a_read_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    !sfr_rd_in |=> $stable(sfr_rdata_out))
    else $error("read data changed without a read");

  // ----------------------------------------
  // checks: data bytes and update sources
  // ----------------------------------------
  // each data byte keeps what was last written to it
  a_high_store: assert property (@(posedge clk_in) disable iff (rst_in)
    high_wr |=> code_high_byte == $past(sfr_wdata_in))
    else $error("high byte write not stored");

  a_high_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    !high_wr |=> $stable(code_high_byte))
    else $error("high byte changed without a write");

  a_low_store: assert property (@(posedge clk_in) disable iff (rst_in)
    low_wr |=> code_low_byte == $past(sfr_wdata_in))
    else $error("low byte write not stored");

  a_low_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    !low_wr |=> $stable(code_low_byte))
    else $error("low byte changed without a write");

  // the selected event must always raise the load
  a_write_load: assert property (@(posedge clk_in) disable iff (rst_in)
    s_write_tick |-> load)
    else $error("high write in write mode did not load");

  a_timer_load: assert property (@(posedge clk_in) disable iff (rst_in)
    s_timer_tick |-> load)
    else $error("selected timer overflow did not load");

  // the latch takes the freshly formatted code on each event
  a_write_update: assert property (@(posedge clk_in) disable iff (rst_in)
    (update_source_select == 2'h0 && high_wr) |=> code_latch_out == $past(cif.code))
    else $error("high write did not update");

  a_t3_update: assert property (@(posedge clk_in) disable iff (rst_in)
    (update_source_select == 2'h1 && t3_ovf_in) |=> code_latch_out == $past(cif.code))
    else $error("timer 3 overflow did not update");

  a_t4_update: assert property (@(posedge clk_in) disable iff (rst_in)
    (update_source_select == 2'h2 && t4_ovf_in) |=> code_latch_out == $past(cif.code))
    else $error("timer 4 overflow did not update");

  a_t2_update: assert property (@(posedge clk_in) disable iff (rst_in)
    (update_source_select == 2'h3 && t2_ovf_in) |=> code_latch_out == $past(cif.code))
    else $error("timer 2 overflow did not update");

  // with no load event the latch must keep its code
  a_no_load_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    !load |=> $stable(code_latch_out))
    else $error("latch changed without a load");

  // a lone low byte write never reaches the latch
  a_low_held: assert property (@(posedge clk_in) disable iff (rst_in)
    (low_wr && !load) |=> $stable(code_latch_out))
    else $error("low write changed output");

  // a high byte write in a timer mode waits for the overflow
  a_timer_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_timer_mode_write ##0 !load) |=> $stable(code_latch_out))
    else $error("timer mode write changed output");

  // low first then high, in write mode, must load
  a_low_high_seq: assert property (@(posedge clk_in) disable iff (rst_in)
    s_low_then_high |-> (update_source_select != 2'h0) || load)
    else $error("high write after low not loading");

  // ----------------------------------------
  // checks: justification
  // ----------------------------------------
  // each layout puts the code's top bit at the field's upper end
  a_fmt_nibble: assert property (@(posedge clk_in) disable iff (rst_in)
    (word_justification_select == 3'h0 && load) |=>
      code_latch_out == {$past(next_high[3:0]), $past(next_low)})
    else $error("000 justification wrong");

  a_fmt_five: assert property (@(posedge clk_in) disable iff (rst_in)
    (word_justification_select == 3'h1 && load) |=>
      code_latch_out == {$past(next_high[4:0]), $past(next_low[7:1])})
    else $error("001 justification wrong");

  a_fmt_six: assert property (@(posedge clk_in) disable iff (rst_in)
    (word_justification_select == 3'h2 && load) |=>
      code_latch_out == {$past(next_high[5:0]), $past(next_low[7:2])})
    else $error("010 justification wrong");

  a_fmt_seven: assert property (@(posedge clk_in) disable iff (rst_in)
    (word_justification_select == 3'h3 && load) |=>
      code_latch_out == {$past(next_high[6:0]), $past(next_low[7:3])})
    else $error("011 justification wrong");

  a_fmt_full: assert property (@(posedge clk_in) disable iff (rst_in)
    (word_justification_select[2] && load) |=>
      code_latch_out == {$past(next_high), $past(next_low[7:4])})
    else $error("1xx justification wrong");
endmodule : dufc_top

/* testbench/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [3:0] tmr = 4'h0;
  logic [7:0] rdata;
  logic [11:0] code;
  logic en;
  logic pin;
  logic sd;
  int failures = 0;
  int samples_checked = 0;
  logic [11:0] exp_code;
  logic [7:0] h;
  logic [7:0] l;

  // half period of 2 ns gives 250 MHz
  always #2 clk_in = ~clk_in;

  // tmr index equals the update source code that selects it
  dufc_top dut (
    .clk_in(clk_in), .rst_in(rst_in), .sfr_addr_in(addr), .sfr_wr_in(wr),
    .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
    .t2_ovf_in(tmr[3]), .t3_ovf_in(tmr[1]), .t4_ovf_in(tmr[2]),
    .code_latch_out(code), .converter_one_enable_out(en),
    .pin_drive_out(pin), .shutdown_out(sd)
  );
  // ----------------------------------------
  // compare and access tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask : cmp8

  task automatic cmp12(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t code %h expected %h", $time, got, exp);
    end
  endtask : cmp12

  task automatic cmp3(input logic [2:0] got, input logic [2:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t flags %b expected %b", $time, got, exp);
    end
  endtask : cmp3

  // waits past the pin latency so callers may compare at once
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(posedge clk_in);
    #1;
    cmp8(rdata, exp);
  endtask : rd_reg

  task automatic pulse(input int i);
    @(posedge clk_in);
    tmr[i] <= 1'b1;
    @(posedge clk_in);
    tmr[i] <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask : pulse

  // expected code, written from the field layouts
  function automatic logic [11:0] fmt(logic [7:0] hb, logic [7:0] lb, logic [2:0] f);
    if (f[2]) return {hb, lb[7:4]};
    case (f[1:0])
      2'h0: return {hb[3:0], lb};
      2'h1: return {hb[4:0], lb[7:1]};
      2'h2: return {hb[5:0], lb[7:2]};
      default: return {hb[6:0], lb[7:3]};
    endcase
  endfunction : fmt
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    cmp3({en, pin, sd}, 3'h1);
    cmp12(code, 12'h000);
    rd_reg(dufc_pkg::CTRL_ADDR, 8'h00);
    wr_reg(dufc_pkg::CTRL_ADDR, 8'hFF);
    rd_reg(dufc_pkg::CTRL_ADDR, 8'h9F);
    cmp3({en, pin, sd}, 3'h6);
    wr_reg(dufc_pkg::CTRL_ADDR, 8'h7F);
    rd_reg(dufc_pkg::CTRL_ADDR, 8'h1F);
    cmp3({en, pin, sd}, 3'h1);
    rd_reg(8'h00, 8'h00);
    // write mode, every justification, stray high bits set on purpose
    exp_code = 12'h000;
    for (int f = 0; f < 8; f++) begin
      h = 8'hC3 + 8'(f * 17);
      l = 8'h5A ^ 8'(f);
      wr_reg(dufc_pkg::CTRL_ADDR, 8'h80 | 8'(f));
      wr_reg(dufc_pkg::LOW_ADDR, l);
      cmp12(code, exp_code);
      wr_reg(dufc_pkg::HIGH_ADDR, h);
      exp_code = fmt(h, l, 3'(f));
      cmp12(code, exp_code);
    end
    // timer modes; other timers must not load, full-scale codes except a zero code for source 10
    for (int m = 1; m < 4; m++) begin
      h = (m == 2) ? 8'h00 : 8'hFF;
      l = h;
      wr_reg(dufc_pkg::CTRL_ADDR, 8'h84 | 8'(m << 3));
      wr_reg(dufc_pkg::LOW_ADDR, l);
      wr_reg(dufc_pkg::HIGH_ADDR, h);
      cmp12(code, exp_code);
      for (int k = 1; k < 4; k++) begin
        if (k != m) pulse(k);
      end
      cmp12(code, exp_code);
      pulse(m);
      exp_code = {h, l[7:4]};
      cmp12(code, exp_code);
    end
    // write mode ignores timer overflows
    wr_reg(dufc_pkg::CTRL_ADDR, 8'h84);
    wr_reg(dufc_pkg::LOW_ADDR, 8'h00);
    pulse(3);
    cmp12(code, exp_code);
    rd_reg(dufc_pkg::LOW_ADDR, 8'h00);
    rd_reg(dufc_pkg::HIGH_ADDR, 8'hFF);
    stop_test();
  end

  // the tests need well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk_in);
    failures++;
    stop_test();
  end
endmodule : testbench
